// [hw/adc_sweep_control.sv]
// Summary of operation
// - sweep mode 1 interleaves priority pin conversions
// - pin count field selects priority pins 0..3
// - software trigger starts on start bit write
// - external trigger arms, starts on falling edge
// - sweep runs until start bit cleared; no interrupt
// - each pin result goes to own register
// - group select substitutes alternate eight-pin groups
// - resolution bit 1 gives 10-bit result
// - resolution bit 0 gives 8-bit result
// - sample-hold: 28 or 33 converter cycles
// - sample-hold in all modes, chosen before start
// - extended pins usable only in one-shot, repeat
// - extended results land in registers 0, 1
// - op-amp mode routes out, converts return pin
// - reference bit 0 disconnects the ladder
// - start refused without reference; no disconnect busy
`timescale 1ns/1ps
`default_nettype none
`include "adc_sweep_regs.svh"

module adc_sweep_control (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  addr_i,             // register offset
  input  wire logic [15:0] wdata_i,            // write data
  input  wire logic        wr_i,               // write strobe
  input  wire logic        rd_i,               // read strobe
  output logic      [15:0] rdata_o,            // read data, cycle after rd_i
  input  wire logic        ext_trigger_pin_i,  // external trigger level
  input  wire logic [9:0]  sample_data_i,      // code from the analog core
  output logic      [1:0]  input_group_o,      // 0 primary, 1 group a, 2 group b
  output logic      [2:0]  input_pin_o,        // pin within the group
  output logic      [1:0]  ext_source_o,       // converter input source
  output logic             opamp_route_o,      // drive pin out on extended zero
  output logic             ladder_connect_o,   // resistor ladder to reference
  output logic             sample_hold_o,      // sample-and-hold in use
  output logic             busy_o,             // a conversion is running
  output logic             result_take_o       // one-cycle pulse per result
);

  // ****************************************************************
  // register fields
  // ****************************************************************
  logic [2:0]             chan_reg,     chan_next;      // single pin
  adc_sweep_pkg::mode_t   mode_reg,     mode_next;      // conversion mode
  logic                   trig_reg,     trig_next;      // trigger select
  logic                   start_reg,    start_next;     // conversion start
  logic [1:0]             scan_reg,     scan_next;      // priority count - 1
  logic                   res_reg,      res_next;       // 1 = 10 bit
  logic                   ref_reg,      ref_next;       // reference connect
  logic [1:0]             ext_reg,      ext_next;       // extended select
  logic                   smp_reg,      smp_next;       // sample-and-hold
  logic [1:0]             grp_reg,      grp_next;       // input group

  // ****************************************************************
  // engine state
  // ****************************************************************
  adc_sweep_pkg::state_t  state_reg,    state_next;
  logic [7:0]             cnt_reg,      cnt_next;       // clocks left
  logic [2:0]             prio_reg,     prio_next;      // latest priority pin
  logic [2:0]             nonp_reg,     nonp_next;      // next other pin
  logic                   phase_reg,    phase_next;     // 1 = other pin now
  logic [2:0]             pin_reg,      pin_next;       // pin being converted
  logic [2:0]             dest_reg,     dest_next;      // result register
  adc_sweep_pkg::source_t src_reg,      src_next;       // converter source
  logic                   route_reg,    route_next;     // op-amp routing
  logic                   take_reg,     take_next;      // result pulse
  logic                   busy_reg,     busy_next;
  logic                   trig_q_reg;                   // last trigger level

  logic                   launch;       // begin first conversion
  logic                   advance;      // begin following conversion
  logic                   oneshot_end;  // one-shot finished
  logic                   mem_we;       // store a result
  logic [9:0]             mem_wdata;    // result code to store
  logic                   trig_fall;    // trigger high-to-low
  logic                   sweep;        // sweep mode 1 selected
  logic [2:0]             prio_cnt;     // number of priority pins
  logic [15:0]            ctrl_rdata;   // control register read value
  logic                   rd_ctrl;      // read at offsets 8..F, not a result word

  // clocks per pin conversion minus one; the converter clock is a
  // divided clk, so the count is scaled by the divider
  function automatic logic [7:0] conv_len(input logic res, input logic sample_hold_enable_bit);
    logic [7:0] cyc;
    cyc = 8'h00;
    if (sample_hold_enable_bit) begin
      cyc = res ? 8'(`CYC_SH_10BIT) : 8'(`CYC_SH_8BIT);
    end else begin
      cyc = res ? 8'(`CYC_NOSH_10BIT) : 8'(`CYC_NOSH_8BIT);
    end
    return 8'(cyc * 8'(`ADC_CLK_DIV) - 8'h01);
  endfunction

  assign sweep     = mode_reg[1];
  assign prio_cnt  = {1'b0, scan_reg} + 3'h1;
  assign trig_fall = trig_q_reg & ~ext_trigger_pin_i;

  // ****************************************************************
  // register file
  // ****************************************************************

  // software writes; hardware clears start at the end of one-shot
  always_comb begin
    chan_next  = chan_reg;
    mode_next  = mode_reg;
    trig_next  = trig_reg;
    scan_next  = scan_reg;
    res_next   = res_reg;
    ref_next   = ref_reg;
    ext_next   = ext_reg;
    smp_next   = smp_reg;
    grp_next   = grp_reg;
    start_next = start_reg & ~oneshot_end;
    if (wr_i && addr_i == `OFS_CTRL_FIRST) begin
      chan_next = wdata_i[`F1_CHAN_LSB +: 3];
      mode_next = adc_sweep_pkg::mode_t'(wdata_i[`F1_MODE_LSB +: 2]);
      trig_next = wdata_i[`F1_TRIG_LSB];
      start_next = wdata_i[`F1_START_LSB] & ref_reg;
    end
    if (wr_i && addr_i == `OFS_CTRL_SECOND) begin
      scan_next = wdata_i[`F2_SCAN_LSB +: 2];
      res_next  = wdata_i[`F2_RES_LSB];
      ext_next  = wdata_i[`F2_EXT_LSB +: 2];
      ref_next  = wdata_i[`F2_REF_LSB] | start_reg;
    end
    if (wr_i && addr_i == `OFS_CTRL_THIRD) begin
      smp_next = wdata_i[`F3_SMP_LSB];
      grp_next = wdata_i[`F3_GRP_LSB +: 2];
    end
  end

  // register update; reset values are all zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      // each field takes its own slice of the reset word, so the enum
      // is loaded by a cast rather than through a concatenation
      chan_reg  <= 3'(`RST_CTRL_FIRST >> `F1_CHAN_LSB);
      mode_reg  <= adc_sweep_pkg::mode_t'(2'(`RST_CTRL_FIRST >> `F1_MODE_LSB));
      trig_reg  <= 1'(`RST_CTRL_FIRST >> `F1_TRIG_LSB);
      start_reg <= 1'(`RST_CTRL_FIRST >> `F1_START_LSB);
      scan_reg  <= 2'(`RST_CTRL_SECOND >> `F2_SCAN_LSB);
      res_reg   <= 1'(`RST_CTRL_SECOND >> `F2_RES_LSB);
      ref_reg   <= 1'(`RST_CTRL_SECOND >> `F2_REF_LSB);
      ext_reg   <= 2'(`RST_CTRL_SECOND >> `F2_EXT_LSB);
      smp_reg   <= 1'(`RST_CTRL_THIRD >> `F3_SMP_LSB);
      grp_reg   <= 2'(`RST_CTRL_THIRD >> `F3_GRP_LSB);
    end else begin
      chan_reg  <= chan_next;
      mode_reg  <= mode_next;
      trig_reg  <= trig_next;
      start_reg <= start_next;
      scan_reg  <= scan_next;
      res_reg   <= res_next;
      ref_reg   <= ref_next;
      ext_reg   <= ext_next;
      smp_reg   <= smp_next;
      grp_reg   <= grp_next;
    end
  end

  // read value of the control registers; unmapped reads give zero
  always_comb begin
    ctrl_rdata = 16'h0000;
    rd_ctrl    = 1'b1;
    unique case (addr_i)
      `OFS_CTRL_FIRST: begin
        ctrl_rdata[`F1_CHAN_LSB +: 3] = chan_reg;
        ctrl_rdata[`F1_MODE_LSB +: 2] = mode_reg;
        ctrl_rdata[`F1_TRIG_LSB]      = trig_reg;
        ctrl_rdata[`F1_START_LSB]     = start_reg;
      end
      `OFS_CTRL_SECOND: begin
        ctrl_rdata[`F2_SCAN_LSB +: 2] = scan_reg;
        ctrl_rdata[`F2_RES_LSB]       = res_reg;
        ctrl_rdata[`F2_REF_LSB]       = ref_reg;
        ctrl_rdata[`F2_EXT_LSB +: 2]  = ext_reg;
      end
      `OFS_CTRL_THIRD: begin
        ctrl_rdata[`F3_SMP_LSB]       = smp_reg;
        ctrl_rdata[`F3_GRP_LSB +: 2]  = grp_reg;
      end
      default: begin
        rd_ctrl = addr_i[3];  // offsets 0..7 are results
      end
    endcase
  end

  // ****************************************************************
  // conversion engine
  // ****************************************************************

  // sequencing of pins; aborts at once when start is cleared, so a
  // result in flight is dropped rather than half-stored
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    prio_next   = prio_reg;
    nonp_next   = nonp_reg;
    phase_next  = phase_reg;
    pin_next    = pin_reg;
    dest_next   = dest_reg;
    src_next    = src_reg;
    route_next  = route_reg;
    take_next   = 1'b0;
    launch      = 1'b0;
    advance     = 1'b0;
    oneshot_end = 1'b0;
    mem_we      = 1'b0;
    mem_wdata   = res_reg ? sample_data_i : {2'b00, sample_data_i[9:2]};
    unique case (state_reg)
      adc_sweep_pkg::ST_IDLE: begin
        if (start_reg) begin
          if (trig_reg) begin
            state_next = adc_sweep_pkg::ST_ARMED;
          end else begin
            launch = 1'b1;
          end
        end
      end
      adc_sweep_pkg::ST_ARMED: begin
        if (!start_reg) begin
          state_next = adc_sweep_pkg::ST_IDLE;
        end else if (trig_fall) begin
          launch = 1'b1;
        end
      end
      adc_sweep_pkg::ST_CONVERT: begin
        if (!start_reg) begin
          state_next = adc_sweep_pkg::ST_IDLE;
        end else if (cnt_reg == 8'h00) begin
          mem_we    = 1'b1;
          take_next = 1'b1;
          if (mode_reg == adc_sweep_pkg::MODE_ONESHOT) begin
            oneshot_end = 1'b1;
            state_next  = adc_sweep_pkg::ST_IDLE;
          end else begin
            advance = 1'b1;
          end
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        state_next = adc_sweep_pkg::ST_IDLE;
      end
    endcase
    if (launch) begin
      // first priority pin, first pin above the priority set
      prio_next  = 3'h0;
      nonp_next  = prio_cnt;
      phase_next = 1'b0;
      state_next = adc_sweep_pkg::ST_CONVERT;
    end
    if (advance && phase_reg) begin
      phase_next = 1'b0;
      prio_next  = (prio_reg + 3'h1 == prio_cnt) ? 3'h0 : prio_reg + 3'h1;
      nonp_next  = (nonp_reg == 3'h7) ? prio_cnt : nonp_reg + 3'h1;
    end else if (advance) begin
      phase_next = 1'b1;
    end
    if (launch || advance) begin
      cnt_next   = conv_len(res_reg, smp_reg);
      src_next   = adc_sweep_pkg::SRC_GROUP;
      route_next = 1'b0;
      if (sweep) begin
        pin_next  = phase_next ? nonp_next : prio_next;
        dest_next = pin_next;
      end else begin
        pin_next  = chan_reg;
        dest_next = chan_reg;
        unique case (ext_reg)
          2'b01: begin
            src_next  = adc_sweep_pkg::SRC_EXT0;
            dest_next = 3'h0;
          end
          2'b10: begin
            src_next  = adc_sweep_pkg::SRC_EXT1;
            dest_next = 3'h1;
          end
          2'b11: begin
            src_next   = adc_sweep_pkg::SRC_EXT1;
            route_next = 1'b1;
          end
          2'b00: begin
            src_next = adc_sweep_pkg::SRC_GROUP;
          end
        endcase
      end
    end
    if (state_next != adc_sweep_pkg::ST_CONVERT) begin
      route_next = 1'b0;
    end
    busy_next = (state_next == adc_sweep_pkg::ST_CONVERT);
  end

  // engine registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg  <= adc_sweep_pkg::ST_IDLE;
      cnt_reg    <= 8'h00;
      prio_reg   <= 3'h0;
      nonp_reg   <= 3'h1;
      phase_reg  <= 1'b0;
      pin_reg    <= 3'h0;
      dest_reg   <= 3'h0;
      src_reg    <= adc_sweep_pkg::SRC_GROUP;
      route_reg  <= 1'b0;
      take_reg   <= 1'b0;
      busy_reg   <= 1'b0;
      trig_q_reg <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      prio_reg   <= prio_next;
      nonp_reg   <= nonp_next;
      phase_reg  <= phase_next;
      pin_reg    <= pin_next;
      dest_reg   <= dest_next;
      src_reg    <= src_next;
      route_reg  <= route_next;
      take_reg   <= take_next;
      busy_reg   <= busy_next;
      trig_q_reg <= ext_trigger_pin_i;
    end
  end

  // result storage and bus read data
  result_mem u_results (
    .clk_i         (clk_i),
    .we_i          (mem_we),
    .waddr_i       (dest_reg),
    .wdata_i       (mem_wdata),
    .raddr_i       (addr_i[2:0]),
    .bypass_i      (rd_ctrl),
    .bypass_data_i (ctrl_rdata),
    .rdata_o       (rdata_o)
  );

  // ****************************************************************
  // outputs, all from flops
  // ****************************************************************
  // group select drives the pin mux
  assign input_group_o    = grp_reg;
  assign input_pin_o      = pin_reg;
  assign ext_source_o     = src_reg;
  assign opamp_route_o    = route_reg;
  assign ladder_connect_o = ref_reg;
  assign sample_hold_o    = smp_reg;
  assign busy_o           = busy_reg;
  assign result_take_o    = take_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_start_needs_ref: assert property (
    @(posedge clk_i) disable iff (!rst_b_i) start_reg |-> ref_reg)
    else $error("start bit set without reference connected");
  a_ladder_idle: assert property (
    @(posedge clk_i) disable iff (!rst_b_i) !ladder_connect_o |-> !busy_o)
    else $error("converting with ladder disconnected");
  a_sw_trigger: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == adc_sweep_pkg::ST_IDLE && start_reg && !trig_reg) |=> busy_o)
    else $error("software trigger did not start");
  a_armed_hold: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (state_reg == adc_sweep_pkg::ST_ARMED && start_reg && !trig_fall)
    |=> state_reg == adc_sweep_pkg::ST_ARMED)
    else $error("armed converter started without trigger edge");
  a_stop_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i) !start_reg |=> !busy_o)
    else $error("conversion continued after start cleared");
  a_conv_len: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (advance && smp_reg && res_reg) |=> cnt_reg == 8'h41 && busy_o)
    else $error("10-bit sample-hold length wrong");
  a_prio_phase: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (busy_o && sweep && $stable(scan_reg)) |-> (phase_reg == (pin_reg >= prio_cnt)))
    else $error("priority interleave broken");
  a_res_8bit: assert property (
    @(posedge clk_i) disable iff (!rst_b_i) (mem_we && !res_reg) |-> mem_wdata[9:8] == 2'b00)
    else $error("8-bit result has high bits");
  a_ext_dest: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (busy_o && src_reg == adc_sweep_pkg::SRC_EXT0) |-> dest_reg == 3'h0)
    else $error("extended zero result misplaced");
  a_opamp_src: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    opamp_route_o |-> (ext_source_o == 2'b10 && dest_reg == pin_reg))
    else $error("op-amp mode source wrong");

endmodule

`default_nettype wire

// [hw/adc_sweep_regs.svh]
`ifndef ADC_SWEEP_REGS_SVH
`define ADC_SWEEP_REGS_SVH

// ****************************************************************
// register offsets on the plain port
// ****************************************************************
`define OFS_RESULT_BASE   4'h0   // result registers 0..7 at 0x0..0x7
`define OFS_CTRL_FIRST    4'h8   // converter_control_first
`define OFS_CTRL_SECOND   4'h9   // converter_control_second
`define OFS_CTRL_THIRD    4'hA   // converter_control_third

// ****************************************************************
// field positions (lsb)
// ****************************************************************
`define F1_CHAN_LSB       0      // 3-bit pin for one-shot / repeat
`define F1_MODE_LSB       3      // 2-bit conversion mode
`define F1_TRIG_LSB       5      // trigger_select_bit
`define F1_START_LSB      6      // conversion_start_bit
`define F2_SCAN_LSB       0      // 2-bit sweep_pin_count_field
`define F2_RES_LSB        3      // resolution select, 1 = 10 bit
`define F2_REF_LSB        5      // reference_connect_bit
`define F2_EXT_LSB        6      // 2-bit extended_input_select_field
`define F3_SMP_LSB        0      // sample_hold_enable_bit
`define F3_GRP_LSB        1      // 2-bit input_group_select_field

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CTRL_FIRST    8'h00
`define RST_CTRL_SECOND   8'h00
`define RST_CTRL_THIRD    8'h00

// ****************************************************************
// timing: clock divider, then lengths in converter clock cycles
// ****************************************************************
`define ADC_CLK_DIV       2      // converter clock = clk / 2
`define CYC_SH_8BIT       28     // with sample-and-hold, 8 bit
`define CYC_SH_10BIT      33     // with sample-and-hold, 10 bit
`define CYC_NOSH_8BIT     49     // without sample-and-hold, 8 bit
`define CYC_NOSH_10BIT    59     // without sample-and-hold, 10 bit

`endif

// [hw/adc_sweep_pkg.sv]
package adc_sweep_pkg;

  // ****************************************************************
  // engine states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,  // stopped
    ST_ARMED   = 2'b01,  // waiting for trigger falling edge
    ST_CONVERT = 2'b10   // a pin conversion is running
  } state_t;

  // conversion modes; 2'b10 is treated as sweep mode 1
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'b00,
    MODE_REPEAT  = 2'b01,
    MODE_SPARE   = 2'b10,
    MODE_SWEEP1  = 2'b11
  } mode_t;

  // what feeds the converter input
  typedef enum logic [1:0] {
    SRC_GROUP = 2'b00,   // selected pin of the input group
    SRC_EXT0  = 2'b01,   // extended_input_zero
    SRC_EXT1  = 2'b10    // extended_input_one
  } source_t;

endpackage

// [hw/result_mem.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// eight result words, read data from a register
// ****************************************************************
module result_mem (
  input  wire logic        clk_i,
  input  wire logic        we_i,        // store a result
  input  wire logic [2:0]  waddr_i,     // result register index
  input  wire logic [9:0]  wdata_i,     // result code
  input  wire logic [2:0]  raddr_i,     // read index
  input  wire logic        bypass_i,    // return bypass data instead
  input  wire logic [15:0] bypass_data_i,
  output logic      [15:0] rdata_o
);

  logic [9:0]  words [8];  // result storage, no reset needed
  logic [15:0] rdata_reg;  // registered read data

  // write port; a read in the same cycle sees the old word
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      words[waddr_i] <= wdata_i;
    end
  end

  // read mux registered so the bus data come from a flop
  always_ff @(posedge clk_i) begin
    if (bypass_i) begin
      rdata_reg <= bypass_data_i;
    end else begin
      rdata_reg <= {6'h00, words[raddr_i]};
    end
  end

  assign rdata_o = rdata_reg;

endmodule

`default_nettype wire

// [sim/analog_sensor_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// analog sensors on the input pins
// ****************************************************************
// each pin answers with a code built from its group and index, so a
// result that lands in the wrong register shows up at once
module analog_sensor_model (
  input  wire logic [1:0] input_group_i,  // selected group
  input  wire logic [2:0] input_pin_i,    // selected pin
  input  wire logic [1:0] ext_source_i,   // converter input source
  output logic      [9:0] sample_data_o   // code seen by the converter
);
  // combinational: a real sensor holds its level, no stale value here
  assign sample_data_o = {input_group_i, input_pin_i, ext_source_i, 3'b101};
endmodule

`default_nettype wire

// [sim/adc_sweep_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module adc_sweep_control_bench;
  logic        clk_i, rst_b_i, wr_i, rd_i, ext_trigger_pin_i;
  logic        rd_pend = 1'b0;  // a read answer is due this cycle
  logic [3:0]  addr_i, ua;
  logic [15:0] wdata_i, rdata_o;
  logic [9:0]  sample_data_i, c;
  logic [1:0]  input_group_o, ext_source_o;
  logic [2:0]  input_pin_o;
  logic [2:0]  last_pin = 3'h0;  // pin shown one cycle earlier
  logic        opamp_route_o, ladder_connect_o, sample_hold_o, busy_o, result_take_o;
  int          mismatches, checked, seed, exp_gap;
  int          gap = 0;  // clocks since busy rise or last result
  logic [15:0] rd_q[$];   // expected read data, oldest first
  logic [2:0]  pin_q[$];  // expected conversion order

  adc_sweep_control i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_trigger_pin_i(ext_trigger_pin_i), .sample_data_i(sample_data_i),
    .input_group_o(input_group_o), .input_pin_o(input_pin_o),
    .ext_source_o(ext_source_o), .opamp_route_o(opamp_route_o),
    .ladder_connect_o(ladder_connect_o), .sample_hold_o(sample_hold_o),
    .busy_o(busy_o), .result_take_o(result_take_o));

  analog_sensor_model i_sensor (.input_group_i(input_group_o),
    .input_pin_i(input_pin_o), .ext_source_i(ext_source_o),
    .sample_data_o(sample_data_i));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [9:0] code(input logic [1:0] g, input logic [2:0] p);
    return {g, p, 2'b00, 3'b101};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes; the extra edge keeps strobes from being set twice
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  // bounded wait until every expected conversion was seen
  task automatic wait_takes();
    repeat (2000) if (pin_q.size() > 0) @(posedge clk_i);
    check("takes_left", 16'(pin_q.size()), 16'h0000);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // output watcher: read data, order of pins, spacing of results
  // ****************************************************************
  always @(posedge clk_i) begin
    if (rd_pend) check("rdata", rdata_o, rd_q.pop_front());
    if (result_take_o && pin_q.size() > 0) begin
      check("pin", 16'(last_pin), 16'(pin_q.pop_front()));
      check("gap", 16'(gap), 16'(exp_gap));
    end
    rd_pend <= rd_i;
    last_pin <= input_pin_o;
    gap <= !busy_o ? 0 : (result_take_o ? 1 : gap + 1);
  end

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // watchdog: whole run needs about 1000 cycles
  initial begin
    #(25 * 20000);
    mismatches++;
    end_sim();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_b_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 4'h0; wdata_i = 16'h0000;
    ext_trigger_pin_i = 1'b1; seed = 32'h89a5; exp_gap = 0;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(4'h8, 16'h0000);
    rd(4'h9, 16'h0000);
    rd(4'hA, 16'h0000);
    ua = 4'hB + 4'(($random(seed) & 32'h0000_7fff) % 5);
    wr(ua, 16'hffff);
    rd(ua, 16'h0000);
    wr(4'h8, 16'h0058);
    rd(4'h8, 16'h0018);
    wr(4'h9, 16'h0020); // reference first
    @(posedge clk_i);
    check("ladder", 16'(ladder_connect_o), 16'h0001);
    // settle the reference ladder for 1 us before any start
    repeat (40) @(posedge clk_i); // reference settle
    $display("test map_and_reference done");
    // sweep mode 1, two priority pins, group b, 10 bit, sample-hold
    // 33 converter cycles at clk/2 between results
    exp_gap = 66;
    pin_q = '{3'd0, 3'd2, 3'd1, 3'd3, 3'd0, 3'd4, 3'd1, 3'd5};
    wr(4'hA, 16'h0005);
    wr(4'h9, 16'h0029);
    wr(4'h8, 16'h0058);
    wait_takes();
    wr(4'h9, 16'h0009);
    rd(4'h9, 16'h0029);
    check("group", 16'(input_group_o), 16'h0002);
    check("smp", 16'(sample_hold_o), 16'h0001);
    wr(4'h8, 16'h0018); // stop before reconfiguring
    repeat (3) @(posedge clk_i);
    check("busy_stop", 16'(busy_o), 16'h0000);
    for (int i = 0; i < 6; i++) rd(4'(i), {6'h00, code(2'd2, 3'(i))});
    $display("test sweep_software done");
    // external trigger, one priority pin, primary group, 8 bit
    // 28 converter cycles at clk/2 between results
    exp_gap = 56;
    pin_q = '{3'd0, 3'd1, 3'd0, 3'd2};
    wr(4'hA, 16'h0001);
    wr(4'h9, 16'h0020);
    wr(4'h8, 16'h0078);
    repeat (4 + ($random(seed) & 15)) @(posedge clk_i);
    check("armed", 16'(busy_o), 16'h0000);
    ext_trigger_pin_i <= 1'b0;
    wait_takes();
    ext_trigger_pin_i <= 1'b1;
    wr(4'h8, 16'h0038);
    for (int i = 0; i < 3; i++) begin
      c = code(2'd0, 3'(i));
      rd(4'(i), {8'h00, c[9:2]});
    end
    wr(4'h9, 16'h0000);
    @(posedge clk_i);
    check("ladder_off", 16'(ladder_connect_o), 16'h0000);
    repeat (3) @(posedge clk_i);
    $display("test sweep_trigger done");
    // one-shot on pin 3 through the op-amp loop, 10 bit, sample-hold
    exp_gap = 66;
    pin_q = '{3'd3};
    wr(4'h9, 16'h00e8); // reference first
    repeat (40) @(posedge clk_i); // reference settle
    wr(4'h8, 16'h0043);
    repeat (2) @(posedge clk_i);
    check("route", 16'(opamp_route_o), 16'h0001);
    check("source", 16'(ext_source_o), 16'h0002);
    wait_takes();
    rd(4'h8, 16'h0003);
    // sensor code of group 0, pin 3, seen on the return pin
    rd(4'h3, 16'h0075);
    check("route_off", 16'(opamp_route_o), 16'h0000);
    $display("test oneshot_opamp done");
    end_sim();
  end
endmodule

`default_nettype wire
